// ### hw/io_fault_param.v
// parameter registers, fault monitors and comm-loss output control of the I/O system
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "io_fault_regs.vh"

module io_fault_param (
    // clock and reset
    input wire mclk_in,
    input wire rst_in,
    input wire ce_in,
    // avalon-mm slave
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    // supply and fault sense pins
    input wire ctrl_supply_bad_in,
    input wire out_supply_bad_in,
    input wire valve_short_in,
    input wire [31:0] valve_open_in,
    input wire sensor_short_in,
    input wire inrush_in,
    input wire [15:0] din_open_in,
    // link state and switch
    input wire comm_error_in,
    input wire [1:0] switch_mode_in,
    // digital inputs
    input wire [15:0] din_pin_in,
    // outputs
    output reg [31:0] valve_drive_out,
    output reg [15:0] din_state_out,
    output reg [15:0] sys_diag_out,
    output reg irq_out
);

    reg [31:0] sys_param;
    reg [31:0] valve_unit;
    reg [31:0] valve_open_en;
    reg [31:0] fault_mode_lo;
    reg [31:0] fault_mode_hi;
    reg [31:0] din_unit;
    reg [15:0] din_open_en;
    reg [31:0] valve_out;
    reg [15:0] irq_status;
    reg [15:0] irq_mask;
    reg [31:0] ch_err_valve;
    reg [15:0] ch_err_din;
    reg valve_short_err;
    reg sensor_short_err;
    reg [22:0] inrush_cnt;
    reg [31:0] hold_val;
    reg acked;

    // 3-flop synchronisers for pins outside the clock domain
    reg [55:0] s1;
    reg [55:0] s2;
    reg [55:0] s3;
    wire [55:0] raw = {switch_mode_in, comm_error_in, inrush_in, sensor_short_in,
                       valve_short_in, out_supply_bad_in, ctrl_supply_bad_in,
                       din_open_in, valve_open_in};
    reg [55:0] clean;

    wire [31:0] v_open = clean[31:0];
    wire [15:0] d_open = clean[47:32];
    wire ctrl_bad = clean[48];
    wire out_bad = clean[49];
    wire v_short = clean[50];
    wire s_short = clean[51];
    wire inrush = clean[52];
    wire comm_err = clean[53];
    wire [1:0] sw_mode = clean[55:54];

    wire [15:0] din_st;
    wire [22:0] filt_cyc;
    wire [22:0] ext_cyc;
    wire [1:0] filt_sel = din_unit[`DU_FILT_LSB+1:`DU_FILT_LSB];
    wire [1:0] ext_sel = din_unit[`DU_EXT_LSB+1:`DU_EXT_LSB];
    wire [63:0] fmode = {fault_mode_hi, fault_mode_lo};

    // inputs rely on the same settings for every channel of the unit
    wire [31:0] filt_cyc_full;
    wire [31:0] ext_cyc_full;
    wire [31:0] inrush_cyc_full = `US_TO_CYC(`INRUSH_US);
    assign filt_cyc_full = (filt_sel == 2'h0) ? `US_TO_CYC(`FILT0_US) :
                           (filt_sel == 2'h1) ? `US_TO_CYC(`FILT1_US) :
                           (filt_sel == 2'h2) ? `US_TO_CYC(`FILT2_US) :
                           `US_TO_CYC(`FILT3_US);
    assign ext_cyc_full = (ext_sel == 2'h0) ? `US_TO_CYC(`EXT0_US) :
                          (ext_sel == 2'h1) ? `US_TO_CYC(`EXT1_US) :
                          (ext_sel == 2'h2) ? `US_TO_CYC(`EXT2_US) :
                          `US_TO_CYC(`EXT3_US);
    // longest count is 5,000,000 cycles, so 23 bits hold every choice
    assign filt_cyc = filt_cyc_full[22:0];
    assign ext_cyc = ext_cyc_full[22:0];

    // ************************************************************
    // input channels
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_din
            din_channel u_ch (
                .mclk_in(mclk_in),
                .rst_in(rst_in),
                .ce_in(ce_in),
                .filt_cyc_in(filt_cyc),
                .ext_cyc_in(ext_cyc),
                .pin_in(din_pin_in[gi]),
                .state_out(din_st[gi])
            );
        end
    endgenerate

    // ************************************************************
    // fault evaluation
    // ************************************************************
    wire inrush_mask = din_unit[`DU_INRUSH_BIT] && (inrush_cnt != 23'h00_0000);
    wire sens_short_seen = s_short && din_unit[`DU_SHORT_MON_BIT] && !inrush_mask;
    wire valve_short_seen = v_short && valve_unit[`VU_SHORT_MON_BIT];
    wire [31:0] next_ch_err_valve = v_open & valve_open_en;
    wire [15:0] next_ch_err_din = d_open & din_open_en;

    reg [15:0] next_diag;
    always @* begin
        next_diag = 16'h0000;
        next_diag[`DIAG_OPEN_BIT] = (|next_ch_err_valve) | (|next_ch_err_din);
        next_diag[`DIAG_SHORT_BIT] = valve_short_err;
        next_diag[`DIAG_SENSOR_SHORT_BIT] = sensor_short_err;
        next_diag[`DIAG_OUT_SUPPLY_BIT] = out_bad && sys_param[`SYS_OUT_MON_BIT];
        next_diag[`DIAG_CTRL_SUPPLY_BIT] = ctrl_bad && sys_param[`SYS_CTRL_MON_BIT];
    end

    // output source: software codes per channel, else the switch for all
    reg [31:0] next_drive;
    reg [1:0] mode;
    integer k;
    always @* begin
        next_drive = valve_out;
        mode = 2'h0;
        if (comm_err) begin
            for (k = 0; k < 32; k = k + 1) begin
                mode = sys_param[`SYS_SRC_SW_BIT] ? fmode[2*k +: 2] : sw_mode;
                case (mode)
                    `FM_FORCE: next_drive[k] = 1'b1;
                    `FM_HOLD: next_drive[k] = hold_val[k];
                    default: next_drive[k] = 1'b0;
                endcase
            end
        end
    end

    // ************************************************************
    // bus decode
    // ************************************************************
    wire access = (avs_read_in || avs_write_in) && !acked;
    reg [31:0] rd_mux;
    always @* begin
        case (avs_address_in)
            `REG_SYS_PARAM: rd_mux = sys_param;
            `REG_VALVE_UNIT: rd_mux = valve_unit;
            `REG_VALVE_OPEN_EN: rd_mux = valve_open_en;
            `REG_FAULT_MODE_LO: rd_mux = fault_mode_lo;
            `REG_FAULT_MODE_HI: rd_mux = fault_mode_hi;
            `REG_DIN_UNIT: rd_mux = din_unit;
            `REG_DIN_OPEN_EN: rd_mux = {16'h0000, din_open_en};
            `REG_VALVE_OUT: rd_mux = valve_out;
            `REG_SYS_DIAG: rd_mux = {16'h0000, sys_diag_out};
            `REG_IRQ_STATUS: rd_mux = {16'h0000, irq_status};
            `REG_IRQ_MASK: rd_mux = {16'h0000, irq_mask};
            `REG_DIN_STATE: rd_mux = {16'h0000, din_state_out};
            `REG_CH_ERR_VALVE: rd_mux = ch_err_valve;
            `REG_CH_ERR_DIN: rd_mux = {16'h0000, ch_err_din};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    wire status_rd = access && avs_read_in && (avs_address_in == `REG_IRQ_STATUS);
    // diagnostic bit that just rose becomes an interrupt event
    wire [15:0] diag_rise = next_diag & ~sys_diag_out;

    // ************************************************************
    // state
    // ************************************************************
    always @(posedge mclk_in) begin
        if (rst_in) begin
            s1 <= 56'h0;
            s2 <= 56'h0;
            s3 <= 56'h0;
            clean <= 56'h0;
            sys_param <= `SYS_PARAM_RST;
            valve_unit <= `VALVE_UNIT_RST;
            valve_open_en <= 32'h0000_0000;
            fault_mode_lo <= `FAULT_MODE_RST;
            fault_mode_hi <= `FAULT_MODE_RST;
            din_unit <= `DIN_UNIT_RST;
            din_open_en <= 16'h0000;
            valve_out <= 32'h0000_0000;
            irq_status <= 16'h0000;
            irq_mask <= 16'h0000;
            ch_err_valve <= 32'h0000_0000;
            ch_err_din <= 16'h0000;
            valve_short_err <= 1'b0;
            sensor_short_err <= 1'b0;
            inrush_cnt <= 23'h00_0000;
            hold_val <= 32'h0000_0000;
            acked <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
            avs_waitrequest_out <= 1'b1;
            valve_drive_out <= 32'h0000_0000;
            din_state_out <= 16'h0000;
            sys_diag_out <= 16'h0000;
            irq_out <= 1'b0;
        end else if (ce_in) begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            clean <= (s2 == s3) ? s3 : clean;
            // one wait cycle, then the answer; acked blocks a double take
            avs_waitrequest_out <= ~access;
            acked <= access;
            if (access && avs_read_in) begin
                avs_readdata_out <= rd_mux;
            end
            // the write lands in the answer cycle, where the master sees waitrequest low
            if (acked && avs_write_in) begin
                case (avs_address_in)
                    `REG_SYS_PARAM: sys_param <= avs_writedata_in & 32'h0000_0007;
                    `REG_VALVE_UNIT: valve_unit <= avs_writedata_in & 32'h0000_0003;
                    `REG_VALVE_OPEN_EN: valve_open_en <= avs_writedata_in;
                    `REG_FAULT_MODE_LO: fault_mode_lo <= avs_writedata_in;
                    `REG_FAULT_MODE_HI: fault_mode_hi <= avs_writedata_in;
                    `REG_DIN_UNIT: din_unit <= avs_writedata_in & 32'h0000_007F;
                    `REG_DIN_OPEN_EN: din_open_en <= avs_writedata_in[15:0];
                    `REG_VALVE_OUT: valve_out <= avs_writedata_in;
                    `REG_IRQ_MASK: irq_mask <= avs_writedata_in[15:0];
                    default: ;
                endcase
            end
            // inrush window restarts on every inrush event
            if (inrush) begin
                inrush_cnt <= inrush_cyc_full[22:0];
            end else if (inrush_cnt != 23'h00_0000) begin
                inrush_cnt <= inrush_cnt - 23'h00_0001;
            end
            // manual mode latches until reset or until the short monitor is switched off; auto follows the fault
            if (valve_short_seen) begin
                valve_short_err <= 1'b1;
            end else if (valve_unit[`VU_AUTO_RST_BIT] || !valve_unit[`VU_SHORT_MON_BIT]) begin
                valve_short_err <= 1'b0;
            end
            if (sens_short_seen) begin
                sensor_short_err <= 1'b1;
            end else if (din_unit[`DU_AUTO_RST_BIT] || !din_unit[`DU_SHORT_MON_BIT]) begin
                sensor_short_err <= 1'b0;
            end
            ch_err_valve <= next_ch_err_valve;
            ch_err_din <= next_ch_err_din;
            if (!comm_err) begin
                hold_val <= valve_out;
            end
            valve_drive_out <= next_drive;
            din_state_out <= din_st;
            sys_diag_out <= next_diag;
            // set wins over the read clear
            irq_status <= (status_rd ? 16'h0000 : irq_status) | diag_rise;
            irq_out <= |(((status_rd ? 16'h0000 : irq_status) | diag_rise) & irq_mask);
        end
    end

endmodule // io_fault_param

// ### hw/io_fault_regs.vh
// register map, field positions, reset values and timing counts of the fault/parameter block
// ****************************************************************
// ****************************************************************
`ifndef IO_FAULT_REGS_VH
`define IO_FAULT_REGS_VH

// word addresses, one per 32-bit register
`define REG_SYS_PARAM 4'h0
`define REG_VALVE_UNIT 4'h1
`define REG_VALVE_OPEN_EN 4'h2
`define REG_FAULT_MODE_LO 4'h3
`define REG_FAULT_MODE_HI 4'h4
`define REG_DIN_UNIT 4'h5
`define REG_DIN_OPEN_EN 4'h6
`define REG_VALVE_OUT 4'h7
`define REG_SYS_DIAG 4'h8
`define REG_IRQ_STATUS 4'h9
`define REG_IRQ_MASK 4'hA
`define REG_DIN_STATE 4'hB
`define REG_CH_ERR_VALVE 4'hC
`define REG_CH_ERR_DIN 4'hD

// system parameter fields
`define SYS_CTRL_MON_BIT 0
`define SYS_OUT_MON_BIT 1
`define SYS_SRC_SW_BIT 2
// valve unit fields
`define VU_SHORT_MON_BIT 0
`define VU_AUTO_RST_BIT 1
// input unit fields
`define DU_SHORT_MON_BIT 0
`define DU_INRUSH_BIT 1
`define DU_FILT_LSB 2
`define DU_EXT_LSB 4
`define DU_AUTO_RST_BIT 6

// fault mode codes
`define FM_CLEAR 2'h0
`define FM_FORCE 2'h1
`define FM_HOLD 2'h2

// diagnostic word bits
`define DIAG_OPEN_BIT 5
`define DIAG_SHORT_BIT 6
`define DIAG_SENSOR_SHORT_BIT 7
`define DIAG_OUT_SUPPLY_BIT 8
`define DIAG_CTRL_SUPPLY_BIT 9

// reset values
`define SYS_PARAM_RST 32'h0000_0000
`define VALVE_UNIT_RST 32'h0000_0000
`define DIN_UNIT_RST 32'h0000_0014
`define FAULT_MODE_RST 32'h0000_0000

// timing, figures in microseconds, clock 25 MHz
`define CLK_MHZ 25
`define INRUSH_US 100000
`define FILT0_US 100
`define FILT1_US 1000
`define FILT2_US 10000
`define FILT3_US 20000
`define EXT0_US 1000
`define EXT1_US 15000
`define EXT2_US 100000
`define EXT3_US 200000
`define US_TO_CYC(u) ((u) * `CLK_MHZ)

`endif

// ### hw/din_channel.v
// one digital input channel: synchroniser, glitch filter and pulse extension
`timescale 1ns/1ps
`include "io_fault_regs.vh"

module din_channel (
    // clock
    input wire mclk_in,
    input wire rst_in,
    input wire ce_in,
    // timing selects
    input wire [22:0] filt_cyc_in,
    input wire [22:0] ext_cyc_in,
    // pin and result
    input wire pin_in,
    output reg state_out
);

    reg sync1;
    reg sync2;
    reg sync3;
    reg filtered;
    reg [22:0] filt_cnt;
    reg [22:0] ext_cnt;

    // ************************************************************
    // filter and extend
    // ************************************************************
    always @(posedge mclk_in) begin
        if (rst_in) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            filtered <= 1'b0;
            filt_cnt <= 23'h00_0000;
            ext_cnt <= 23'h00_0000;
            state_out <= 1'b0;
        end else if (ce_in) begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            // a level must stand for the filter time before it is believed
            if (sync2 != sync3 || sync3 == filtered) begin
                filt_cnt <= 23'h00_0000;
            end else if (filt_cnt + 23'h00_0001 >= filt_cyc_in) begin
                filtered <= sync3;
                filt_cnt <= 23'h00_0000;
            end else begin
                filt_cnt <= filt_cnt + 23'h00_0001;
            end
            if (filtered) begin
                ext_cnt <= ext_cyc_in;
                state_out <= 1'b1;
            end else if (ext_cnt != 23'h00_0000) begin
                ext_cnt <= ext_cnt - 23'h00_0001;
                state_out <= 1'b1;
            end else begin
                state_out <= 1'b0;
            end
        end
    end

endmodule // din_channel

// ### tb/io_fault_param_properties.sv
// port-level assertions for the fault and parameter block
`timescale 1ns/1ps

module io_fault_param_properties (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // bus handshake
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    // fault sense and results
    input wire logic ctrl_supply_bad_in,
    input wire logic out_supply_bad_in,
    input wire logic [31:0] valve_open_in,
    input wire logic [15:0] din_open_in,
    input wire logic [31:0] valve_drive_out,
    input wire logic [15:0] sys_diag_out,
    input wire logic irq_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    // ****************************************************************
    // bus answer
    // ****************************************************************
    a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property ($fell(avs_waitrequest_out) |->
        $past(avs_read_in || avs_write_in)) else $error("answer without a request");
    a_answer_bound: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |-> ##[0:2] !avs_waitrequest_out) else $error("request not answered in time");
    a_idle_wait: assert property (!avs_read_in && !avs_write_in && !$past(avs_read_in)
        && !$past(avs_write_in) |-> avs_waitrequest_out) else $error("waitrequest low while idle");

    // ****************************************************************
    // diagnostics follow their causes; the supply flags are live, not latched
    // ****************************************************************
    a_ctrl_quiet: assert property (!ctrl_supply_bad_in [*8] |=> !sys_diag_out[9])
        else $error("control supply error without cause");
    a_out_quiet: assert property (!out_supply_bad_in [*8] |=> !sys_diag_out[8])
        else $error("output supply error without cause");
    a_open_quiet: assert property ((valve_open_in == 32'h0000_0000 &&
        din_open_in == 16'h0000) [*8] |=> !sys_diag_out[5]) else $error("open bit without cause");
    a_reset_clear: assert property (disable iff (1'b0) rst_in |=> valve_drive_out == 32'h0000_0000
        && sys_diag_out == 16'h0000 && !irq_out && avs_waitrequest_out) else $error("reset state wrong");
endmodule // io_fault_param_properties

bind io_fault_param io_fault_param_properties chk (.mclk_in, .rst_in, .avs_read_in,
    .avs_write_in, .avs_waitrequest_out, .ctrl_supply_bad_in, .out_supply_bad_in,
    .valve_open_in, .din_open_in, .valve_drive_out, .sys_diag_out, .irq_out);

// ### tb/fieldbus_master.sv
// network master model: reads and writes parameter objects over the register bus
`timescale 1ns/1ps

module fieldbus_master (
    // clock
    input wire logic mclk_in,
    // answer from the block
    input wire logic wait_in,
    input wire logic [31:0] rdata_in,
    // request to the block
    output logic [3:0] addr_out,
    output logic read_out,
    output logic write_out,
    output logic [31:0] wdata_out
);
    initial begin
        addr_out = 4'h0;
        read_out = 1'b0;
        write_out = 1'b0;
        wdata_out = 32'h0000_0000;
    end

    // one whole transfer; the request is held until waitrequest is seen low
    task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] wd,
                        output logic [31:0] q);
        int n;
        @(posedge mclk_in);
        addr_out <= a;
        read_out <= rd;
        write_out <= !rd;
        wdata_out <= wd;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (wait_in && n < 50);
        q = rdata_in;
        read_out <= 1'b0;
        write_out <= 1'b0;
        // released data no longer carries the old value
        wdata_out <= ~wd;
        if (wait_in) begin
            io_fault_param_tb.failures++;
            io_fault_param_tb.print_verdict();
        end
    endtask
endmodule // fieldbus_master

// ### tb/io_fault_param_tb.sv
// self-checking bench for the fault and parameter block
`timescale 1ns/1ps
`include "io_fault_regs.vh"

module io_fault_param_tb;
    // ****************************************************************
    // stimulus and wiring
    // ****************************************************************
    logic mclk_in = 1'b0, rst_in = 1'b1, avs_read_in, avs_write_in, avs_waitrequest_out, irq_out;
    logic ctrl_supply_bad_in = 1'b0, out_supply_bad_in = 1'b0, valve_short_in = 1'b0;
    logic comm_error_in = 1'b0, sensor_short_in = 1'b0, inrush_in = 1'b0;
    logic [1:0] switch_mode_in = 2'h0;
    logic [3:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, valve_drive_out, q;
    logic [31:0] valve_open_in = 32'h0000_0000;
    logic [15:0] din_pin_in = 16'h0000, din_state_out, sys_diag_out;
    logic [15:0] din_open_in = 16'h0000;
    int failures = 0;
    int n_tests = 0;

    always #20 mclk_in = ~mclk_in;

    io_fault_param DUT (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .ctrl_supply_bad_in(ctrl_supply_bad_in), .out_supply_bad_in(out_supply_bad_in),
        .valve_short_in(valve_short_in), .valve_open_in(valve_open_in),
        .sensor_short_in(sensor_short_in), .inrush_in(inrush_in),
        .din_open_in(din_open_in), .comm_error_in(comm_error_in),
        .switch_mode_in(switch_mode_in), .din_pin_in(din_pin_in),
        .valve_drive_out(valve_drive_out), .din_state_out(din_state_out),
        .sys_diag_out(sys_diag_out), .irq_out(irq_out));

    fieldbus_master bm (.mclk_in(mclk_in), .wait_in(avs_waitrequest_out),
        .rdata_in(avs_readdata_out), .addr_out(avs_address_in), .read_out(avs_read_in),
        .write_out(avs_write_in), .wdata_out(avs_writedata_in));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bm.xfer(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a);
        bm.xfer(1'b1, a, 32'h0000_0000, q);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        rst_in <= 1'b1;
        cyc(3);
        rst_in <= 1'b0;
        rd(`REG_SYS_PARAM);
        chk(q, `SYS_PARAM_RST);
        rd(`REG_DIN_UNIT);
        chk(q, `DIN_UNIT_RST);
        rd(`REG_FAULT_MODE_HI);
        chk(q, `FAULT_MODE_RST);
        wr(4'hF, 32'hFFFF_FFFF);
        rd(4'hF);
        chk(q, 32'h0000_0000);
        chk({16'h0000, sys_diag_out}, 32'h0000_0000);
        $display("reset test done");
    endtask
    task automatic t_supply;
        ctrl_supply_bad_in <= 1'b1;
        out_supply_bad_in <= 1'b1;
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0000);
        // a set mask bit lets its status bit through
        wr(`REG_IRQ_MASK, 32'h0000_0100);
        wr(`REG_SYS_PARAM, 32'h0000_0003);
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0300);
        chk({31'h0, irq_out}, 32'h0000_0001);
        rd(`REG_IRQ_STATUS);
        chk(q, 32'h0000_0300);
        rd(`REG_IRQ_STATUS);
        chk(q, 32'h0000_0000);
        cyc(3);
        chk({31'h0, irq_out}, 32'h0000_0000);
        ctrl_supply_bad_in <= 1'b0;
        out_supply_bad_in <= 1'b0;
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0000);
        $display("supply test done");
    endtask
    task automatic t_open;
        valve_open_in <= 32'h0000_0008;
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0000);
        wr(`REG_VALVE_OPEN_EN, 32'h0000_0008);
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0020);
        rd(`REG_CH_ERR_VALVE);
        chk(q, 32'h0000_0008);
        valve_open_in <= 32'h0000_0000;
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0000);
        din_open_in <= 16'h0002;
        cyc(12);
        rd(`REG_CH_ERR_DIN);
        chk(q, 32'h0000_0000);
        wr(`REG_DIN_OPEN_EN, 32'h0000_0002);
        cyc(12);
        rd(`REG_CH_ERR_DIN);
        chk(q, 32'h0000_0002);
        chk({16'h0000, sys_diag_out}, 32'h0000_0020);
        din_open_in <= 16'h0000;
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0000);
        $display("open circuit test done");
    endtask
    task automatic t_comm;
        // ch0 off, ch1 forced, ch2 hold, ch3 forced
        wr(`REG_FAULT_MODE_LO, 32'h0000_0064);
        wr(`REG_VALVE_OUT, 32'h0000_0005);
        wr(`REG_SYS_PARAM, 32'h0000_0004);
        cyc(12);
        chk(valve_drive_out, 32'h0000_0005);
        comm_error_in <= 1'b1;
        cyc(12);
        chk(valve_drive_out, 32'h0000_000E);
        switch_mode_in <= 2'h1;
        wr(`REG_SYS_PARAM, 32'h0000_0000);
        cyc(12);
        chk(valve_drive_out, 32'hFFFF_FFFF);
        switch_mode_in <= 2'h2;
        cyc(12);
        chk(valve_drive_out, 32'h0000_0005);
        switch_mode_in <= 2'h0;
        cyc(12);
        chk(valve_drive_out, 32'h0000_0000);
        comm_error_in <= 1'b0;
        cyc(12);
        chk(valve_drive_out, 32'h0000_0005);
        $display("comm loss test done");
    endtask
    task automatic t_short;
        wr(`REG_VALVE_UNIT, 32'h0000_0002);
        valve_short_in <= 1'b1;
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0000);
        wr(`REG_VALVE_UNIT, 32'h0000_0003);
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0040);
        valve_short_in <= 1'b0;
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0000);
        wr(`REG_VALVE_UNIT, 32'h0000_0001);
        valve_short_in <= 1'b1;
        cyc(12);
        valve_short_in <= 1'b0;
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0040);
        $display("short circuit test done");
    endtask
    task automatic t_sensor;
        // short monitor, inrush filter and auto restart on
        wr(`REG_DIN_UNIT, 32'h0000_0043);
        inrush_in <= 1'b1;
        cyc(3);
        inrush_in <= 1'b0;
        sensor_short_in <= 1'b1;
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0000);
        wr(`REG_DIN_UNIT, 32'h0000_0041);
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0080);
        sensor_short_in <= 1'b0;
        cyc(12);
        chk({16'h0000, sys_diag_out}, 32'h0000_0000);
        $display("sensor short test done");
    endtask
    task automatic t_din;
        // shortest filter (2500 cycles) and extension (25000 cycles) keep the run short
        wr(`REG_DIN_UNIT, 32'h0000_0000);
        din_pin_in <= 16'h0001;
        cyc(1500);
        din_pin_in <= 16'h0000;
        cyc(3000);
        chk({16'h0000, din_state_out}, 32'h0000_0000);
        din_pin_in <= 16'h0001;
        cyc(3000);
        chk({16'h0000, din_state_out}, 32'h0000_0001);
        din_pin_in <= 16'h0000;
        cyc(20000);
        chk({16'h0000, din_state_out}, 32'h0000_0001);
        cyc(10000);
        chk({16'h0000, din_state_out}, 32'h0000_0000);
        $display("input filter test done");
    endtask

    initial begin
        t_reset();
        t_supply();
        t_open();
        t_comm();
        t_short();
        t_reset();
        t_sensor();
        t_din();
        print_verdict();
    end
endmodule // io_fault_param_tb
